// ---- src/rx_fifo_mem.sv ----
`timescale 1ns/10ps
// Byte store for the receive FIFO; read data leave a register.
module rx_fifo_mem
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
)
(
  input logic sys_clk,
  input logic rst,
  input logic wrEn,
  input logic [AW-1:0] wrAddr,
  input logic [WIDTH-1:0] wrData,
  input logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array, not reset.
  logic [WIDTH-1:0] rdData_d;

  // A write to the address being read is passed through, so a byte
  // pushed into an empty FIFO is seen on the next cycle.
  always_comb
  begin
    rdData_d = mem[rdAddr];
    if (wrEn && wrAddr == rdAddr)
    begin
      rdData_d = wrData;
    end
  end

  // Storage write.
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read register.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= '0;
    end
    else
    begin
      rdData <= rdData_d;
    end
  end
endmodule

// ---- src/rx_front_pkg.sv ----
package rx_front_pkg;
  // ----------------------------------------
  // Register byte offsets.
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRE = 8'h04;
  localparam logic [7:0] OFS_SYNC = 8'h08;
  localparam logic [7:0] OFS_FOFS1 = 8'h0c;
  localparam logic [7:0] OFS_FOFS2 = 8'h10;
  localparam logic [7:0] OFS_FIFO = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_AFULL = 8'h20;
  // ----------------------------------------
  // Field positions and reset values.
  // ----------------------------------------
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_TRACK = 1;
  localparam int CTRL_REV = 2;
  localparam int CTRL_SLEN = 4;
  localparam int PRE_LIM = 8;
  localparam int STAT_CNT = 8;
  localparam logic [5:0] CTRL_RST = 6'h38;
  localparam logic [4:0] PRETH_RST = 5'h02;
  localparam logic [5:0] PRELIM_RST = 6'h10;
  localparam logic [31:0] SYNC_RST = 32'h2dd4_2dd4;
  localparam logic [6:0] AFULL_RST = 7'h37;
  // Settling lengths in bits, longer while tracking is on.
  localparam logic [7:0] SETTLE_BITS = 8'h08;
  localparam logic [7:0] SETTLE_TRACK_BITS = 8'h10;
  // ----------------------------------------
  // Events, revisions, responses, states.
  // ----------------------------------------
  localparam int EV_PRE = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_NOPRE = 2;
  localparam int EV_AFULL = 3;
  localparam int EV_OVF = 4;
  localparam int EV_W = 5;
  localparam logic [1:0] REV_EARLY = 2'h0;
  localparam logic [1:0] REV_MID = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {RX_OFF, RX_SETTLE, RX_PREAMBLE, RX_SYNC, RX_PAYLOAD} rx_state_type;
endpackage

// ---- src/rx_preamble_sync_front_end.sv ----
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// Receive front end: preamble timer, preamble and sync search, FIFO.
module rx_preamble_sync_front_end
#(
  parameter int FIFO_DEPTH = 64
)
(
  input logic sys_clk,
  input logic rst,
  input logic [rx_front_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [rx_front_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic demodBit,
  input logic demodBitValid,
  input logic [15:0] measOffset,
  input logic measOffsetValid,
  output logic irq
);
  import rx_front_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(FIFO_DEPTH);

  // ----------------------------------------
  // Register and bus state.
  // ----------------------------------------
  logic [ADDR_W-1:0] awAddr_q, awAddr_d, arAddr_q, arAddr_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awRdy_q, awRdy_d, wRdy_q, wRdy_d, arRdy_q, arRdy_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, rdPend_q, rdPend_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0] ctrl_q, ctrl_d;  // Enable, tracking, revision, sync length.
  logic [4:0] preTh_q, preTh_d;  // Preamble threshold in nibbles.
  logic [5:0] preLim_q, preLim_d;  // Early-variant timeout limit.
  logic [31:0] sync_q, sync_d;  // Sync pattern, first byte on top.
  logic [15:0] fofs_q, fofs_d;  // Frequency offset, both halves.
  logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d, events;
  logic [PW:0] afullTh_q, afullTh_d;
  logic irq_q, irq_d;
  logic pop;
  logic [31:0] merged, wrOld;

  // ----------------------------------------
  // Receive and FIFO state.
  // ----------------------------------------
  rx_state_type state_q, state_d;
  logic [9:0] timer_q, timer_d, tmo;
  logic tmoDone_q, tmoDone_d, rxEnPrev_q, prevBit_q, prevBit_d;
  logic [7:0] preCnt_q, preCnt_d, settle_q, settle_d, preNeed;
  logic [31:0] shift_q, shift_d, newShift, syncPat, syncMask;
  logic [5:0] syncBits_q, syncBits_d, syncNeed;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] byte_q, byte_d, byteNew, memRd;
  logic push, preEv, syncEv, noPreEv, ovfEv, rxEn, trackEn;
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0] count_q, count_d;
  logic aFull_q, aFull_d;

  assign rxEn = ctrl_q[CTRL_RXEN];
  assign trackEn = ctrl_q[CTRL_TRACK];

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] mergeLanes(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Bus slave, registers and interrupt.
  // ----------------------------------------
  // Writes complete one cycle after both address and data are held.
  // Reads answer one cycle after the address is taken, which gives the
  // FIFO store a cycle to present its registered byte.
  always_comb
  begin
    {awAddr_d, awHave_d, wData_d, wStrb_d, wHave_d} = {awAddr_q, awHave_q, wData_q, wStrb_q, wHave_q};
    {bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d} = {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
    {arAddr_d, rdPend_d, ctrl_d, preTh_d, preLim_d} = {arAddr_q, rdPend_q, ctrl_q, preTh_q, preLim_q};
    {sync_d, fofs_d, mask_d, afullTh_d} = {sync_q, fofs_q, mask_q, afullTh_q};
    pop = 1'b0;
    stat_d = stat_q;
    wrOld = 32'h0;
    case (awAddr_q)
      OFS_CTRL: wrOld = {26'h0, ctrl_q};
      OFS_PRE: wrOld = {18'h0, preLim_q, 3'h0, preTh_q};
      OFS_SYNC: wrOld = sync_q;
      OFS_FOFS1: wrOld = {24'h0, fofs_q[15:8]};
      OFS_FOFS2: wrOld = {24'h0, fofs_q[7:0]};
      OFS_MASK: wrOld = {{(32-EV_W){1'b0}}, mask_q};
      OFS_AFULL: wrOld = {{(31-PW){1'b0}}, afullTh_q};
      default: wrOld = 32'h0;
    endcase
    merged = mergeLanes(wrOld, wData_q, wStrb_q);
    if (s_axi_awvalid && awRdy_q)
    begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wRdy_q)
    begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (awHave_q && wHave_q && !bvalid_q)
    begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awAddr_q)
        OFS_CTRL: ctrl_d = merged[5:0];
        OFS_PRE:
        begin
          preTh_d = merged[4:0];
          preLim_d = merged[PRE_LIM +: 6];
        end
        OFS_SYNC: sync_d = merged;
        OFS_FOFS1: fofs_d[15:8] = merged[7:0];
        OFS_FOFS2: fofs_d[7:0] = merged[7:0];
        OFS_MASK: mask_d = merged[EV_W-1:0];
        OFS_AFULL: afullTh_d = merged[PW:0];
        OFS_FIFO, OFS_STAT: bresp_d = RESP_OKAY;  // Read-only, write ignored.
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arRdy_q)
    begin
      rdPend_d = 1'b1;
      arAddr_d = s_axi_araddr;
    end
    if (rdPend_q)
    begin
      rdPend_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0;
      case (arAddr_q)
        OFS_CTRL: rdata_d = {26'h0, ctrl_q};
        OFS_PRE: rdata_d = {18'h0, preLim_q, 3'h0, preTh_q};
        OFS_SYNC: rdata_d = sync_q;
        OFS_FOFS1: rdata_d = {24'h0, fofs_q[15:8]};
        OFS_FOFS2: rdata_d = {24'h0, fofs_q[7:0]};
        OFS_MASK: rdata_d = {{(32-EV_W){1'b0}}, mask_q};
        OFS_AFULL: rdata_d = {{(31-PW){1'b0}}, afullTh_q};
        OFS_FIFO:
        begin
          // An empty FIFO reads as zero and does not move.
          pop = (count_q != '0);
          rdata_d = pop ? {24'h0, memRd} : 32'h0;
        end
        OFS_STAT:
        begin
          rdata_d[EV_W-1:0] = stat_q;
          rdata_d[STAT_CNT +: PW+1] = count_q;
          stat_d = 5'h00;  // Read clears the sticky bits.
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    awRdy_d = !awHave_d;
    wRdy_d = !wHave_d;
    arRdy_d = !rdPend_d && !rvalid_d;
    // Hardware capture overrides a host write in the same cycle.
    if (trackEn && measOffsetValid)
    begin
      fofs_d = measOffset;
    end
    // A new event wins over the read that clears it.
    stat_d = stat_d | events;
    irq_d = |(stat_d & mask_d);
  end

  // Bus and register flip-flops.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {awAddr_q, awHave_q, wData_q, wStrb_q, wHave_q} <= '0;
      {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q} <= '0;
      {arAddr_q, rdPend_q, fofs_q, stat_q, mask_q, irq_q} <= '0;
      {awRdy_q, wRdy_q, arRdy_q} <= 3'h7;
      ctrl_q <= CTRL_RST;
      preTh_q <= PRETH_RST;
      preLim_q <= PRELIM_RST;
      sync_q <= SYNC_RST;
      afullTh_q <= (PW+1)'(AFULL_RST);
    end
    else
    begin
      {awAddr_q, awHave_q, wData_q, wStrb_q, wHave_q} <= {awAddr_d, awHave_d, wData_d, wStrb_d, wHave_d};
      {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q} <= {bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d};
      {arAddr_q, rdPend_q, fofs_q, stat_q, mask_q, irq_q} <= {arAddr_d, rdPend_d, fofs_d, stat_d, mask_d, irq_d};
      {awRdy_q, wRdy_q, arRdy_q} <= {awRdy_d, wRdy_d, arRdy_d};
      {ctrl_q, preTh_q, preLim_q, sync_q, afullTh_q} <= {ctrl_d, preTh_d, preLim_d, sync_d, afullTh_d};
    end
  end

  assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awRdy_q, wRdy_q, arRdy_q};
  assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} = {bvalid_q, bresp_q, rvalid_q, rresp_q};
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;
  assign events = {ovfEv, aFull_d && !aFull_q, noPreEv, syncEv, preEv};

  // ----------------------------------------
  // Bit receiver.
  // ----------------------------------------
  // Demodulated bits come from logic on this clock, qualified by
  // demodBitValid, so they need no synchroniser.
  always_comb
  begin
    case (ctrl_q[CTRL_REV +: 2])
      REV_EARLY: tmo = {4'h0, preLim_q[5:2], 2'b00};
      REV_MID: tmo = 10'h004 + {({1'b0, preTh_q} + 6'h01), 4'h0};
      default: tmo = {3'h0, ({1'b0, preTh_q} + 6'h02), 1'b0};
    endcase
    preNeed = (preTh_q == 5'h00) ? 8'h01 : {1'b0, preTh_q, 2'b00};
    syncPat = sync_q >> {~ctrl_q[CTRL_SLEN +: 2], 3'b000};
    syncMask = 32'hffff_ffff >> {~ctrl_q[CTRL_SLEN +: 2], 3'b000};
    syncNeed = {({1'b0, ctrl_q[CTRL_SLEN +: 2]} + 3'h1), 3'b000};
    newShift = {shift_q[30:0], demodBit};
    byteNew = {byte_q[6:0], demodBit};
    {state_d, timer_d, tmoDone_d, prevBit_d, preCnt_d} = {state_q, timer_q, tmoDone_q, prevBit_q, preCnt_q};
    {settle_d, shift_d, syncBits_d, bitCnt_d, byte_d} = {settle_q, shift_q, syncBits_q, bitCnt_q, byte_q};
    {push, preEv, syncEv, noPreEv, ovfEv} = 5'h00;
    if (!rxEn)
    begin
      state_d = RX_OFF;
    end
    else if (!rxEnPrev_q)
    begin
      // Receiver just switched on: timer and counters restart.
      state_d = RX_SETTLE;
      timer_d = 10'h000;
      tmoDone_d = 1'b0;
      settle_d = 8'h00;
      preCnt_d = 8'h00;
    end
    else if (demodBitValid)
    begin
      // The timer counts bit periods until it fires or a preamble ends it.
      if ((state_q == RX_SETTLE || state_q == RX_PREAMBLE) && !tmoDone_q)
      begin
        timer_d = timer_q + 10'h001;
        if (tmo != 10'h000 && timer_d == tmo)
        begin
          noPreEv = 1'b1;
          tmoDone_d = 1'b1;
        end
      end
      case (state_q)
        RX_SETTLE:
        begin
          settle_d = settle_q + 8'h01;
          if (settle_d >= (trackEn ? SETTLE_TRACK_BITS : SETTLE_BITS))
          begin
            state_d = RX_PREAMBLE;
          end
        end
        RX_PREAMBLE:
        begin
          // Two equal bits in a row restart the run of alternation.
          if (preCnt_q != 8'h00 && demodBit == prevBit_q)
          begin
            preCnt_d = 8'h01;
          end
          else if (preCnt_q != 8'hff)
          begin
            preCnt_d = preCnt_q + 8'h01;
          end
          prevBit_d = demodBit;
          if (preCnt_d >= preNeed)
          begin
            preEv = 1'b1;
            noPreEv = 1'b0;
            tmoDone_d = 1'b1;
            timer_d = 10'h000;
            state_d = RX_SYNC;
            shift_d = 32'h0;
            syncBits_d = 6'h00;
          end
        end
        RX_SYNC:
        begin
          shift_d = newShift;
          syncBits_d = (syncBits_q == 6'h3f) ? syncBits_q : syncBits_q + 6'h01;
          if (syncBits_d >= syncNeed && (newShift & syncMask) == syncPat)
          begin
            syncEv = 1'b1;
            state_d = RX_PAYLOAD;
            bitCnt_d = 3'h0;
          end
        end
        RX_PAYLOAD:
        begin
          byte_d = byteNew;
          bitCnt_d = bitCnt_q + 3'h1;
          if (bitCnt_q == 3'h7)
          begin
            // A byte arriving at a full FIFO is dropped and flagged.
            push = (count_q < DEPTH_C);
            ovfEv = !push;
          end
        end
        default: state_d = RX_OFF;
      endcase
    end
  end

  // Receiver flip-flops.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= RX_OFF;
      {timer_q, tmoDone_q, rxEnPrev_q, prevBit_q, preCnt_q} <= '0;
      {settle_q, shift_q, syncBits_q, bitCnt_q, byte_q} <= '0;
    end
    else
    begin
      state_q <= state_d;
      {timer_q, tmoDone_q, rxEnPrev_q, prevBit_q, preCnt_q} <= {timer_d, tmoDone_d, rxEn, prevBit_d, preCnt_d};
      {settle_q, shift_q, syncBits_q, bitCnt_q, byte_q} <= {settle_d, shift_d, syncBits_d, bitCnt_d, byte_d};
    end
  end

  // ----------------------------------------
  // Receive FIFO pointers and almost-full.
  // ----------------------------------------
  always_comb
  begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
    aFull_d = (count_d >= afullTh_d);
  end

  // FIFO flip-flops.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {wrPtr_q, rdPtr_q, count_q, aFull_q} <= '0;
    end
    else
    begin
      {wrPtr_q, rdPtr_q, count_q, aFull_q} <= {wrPtr_d, rdPtr_d, count_d, aFull_d};
    end
  end

  rx_fifo_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(PW)) fifoMem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(push),
    .wrAddr(wrPtr_q),
    .wrData(byteNew),
    .rdAddr(rdPtr_d),
    .rdData(memRd)
  );

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_offset_capture: assert property (trackEn && measOffsetValid |=> fofs_q == $past(measOffset))
    else $error("offset not captured");
  a_timer_start: assert property (rxEn && !rxEnPrev_q |=> state_q == RX_SETTLE && timer_q == 10'h000)
    else $error("timer did not restart");
  a_timeout_flag: assert property (noPreEv |=> stat_q[EV_NOPRE] && (irq_q || !mask_q[EV_NOPRE]))
    else $error("timeout not flagged");
  a_timeout_early: assert property (noPreEv && ctrl_q[3:2] == 2'h0 |-> timer_q + 10'h001 == 10'(preLim_q[5:2]) * 10'h004)
    else $error("early timeout length wrong");
  a_timeout_mid: assert property (noPreEv && ctrl_q[3:2] == 2'h1 |-> timer_q + 10'h001 == 10'h004 + 10'h010 * (10'(preTh_q) + 10'h001))
    else $error("middle timeout length wrong");
  a_timeout_late: assert property (noPreEv && ctrl_q[3] |-> timer_q + 10'h001 == (10'(preTh_q) + 10'h002) * 10'h002)
    else $error("late timeout length wrong");
  a_sync_gated: assert property (syncEv |-> state_q == RX_SYNC && $past(state_q) inside {RX_SYNC, RX_PREAMBLE})
    else $error("sync seen without preamble");
  a_sync_payload: assert property (syncEv ##1 rxEn |-> state_q == RX_PAYLOAD && stat_q[EV_SYNC])
    else $error("sync did not open payload");
  a_fifo_level: assert property (count_q <= DEPTH_C && (aFull_q == (count_q >= afullTh_q)))
    else $error("fifo level or almost-full wrong");
  a_timer_stopped: assert property (state_q == RX_SYNC |-> !noPreEv && tmoDone_q && timer_q == 10'h000)
    else $error("timer ran after preamble");
endmodule

// ---- verification/demod_source.sv ----
`timescale 1ns/10ps
// ------
// Demodulator stand-in: one bit strobe every four clocks.
// ------
module demod_source
(
  input logic sysClk,
  output logic demodBit,
  output logic demodBitValid,
  output logic [15:0] measOffset,
  output logic measOffsetValid
);
  // Idle levels at time zero.
  initial
  begin
    demodBit = 1'b0;
    demodBitValid = 1'b0;
    measOffset = 16'h0000;
    measOffsetValid = 1'b0;
  end

  // Sends n copies of one bit; the line flips between strobes so a stale value never looks valid.
  task automatic sendConst(input logic b, input int n);
    for (int i = 0; i < n; i++)
    begin
      demodBit <= b;
      demodBitValid <= 1'b1;
      @(posedge sysClk);
      demodBitValid <= 1'b0;
      demodBit <= ~b;
      repeat (3) @(posedge sysClk);
    end
  endtask

  // Sends one byte, most significant bit first.
  task automatic sendByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      sendConst(v[i], 1);
    end
  endtask

  // Offers one offset measurement for a single cycle.
  task automatic offset(input logic [15:0] v);
    measOffset <= v;
    measOffsetValid <= 1'b1;
    @(posedge sysClk);
    measOffsetValid <= 1'b0;
    measOffset <= ~v;
  endtask
endmodule

// ---- verification/rx_preamble_sync_front_end_tb.sv ----
`timescale 1ns/10ps
module rx_preamble_sync_front_end_tb;
  import rx_front_pkg::*;
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic demodBit, demodBitValid, measOffsetValid;
  logic [15:0] measOffset;
  int errCount = 0;
  int nTests = 0;
  int cycles = 0;

  // A small FIFO keeps the fill tests short.
  rx_preamble_sync_front_end #(.FIFO_DEPTH(8)) uut (.sys_clk(sysClk), .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .demodBit, .demodBitValid, .measOffset, .measOffsetValid, .irq);
  demod_source src (.sysClk, .demodBit, .demodBitValid, .measOffset, .measOffsetValid);

  // ------
  // Clock, hang guard and verdict.
  // ------
  initial
  begin
    forever #10 sysClk = ~sysClk;
  end

  // The whole run needs well under this many cycles.
  always @(posedge sysClk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ------
  // Bus tasks; each starts and ends just after a clock edge.
  // ------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sysClk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sysClk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    chk(d, e);
  endtask

  // ------
  // Scenarios.
  // ------
  task automatic testResetValues();
    logic [31:0] d;
    logic [1:0] r;
    rdChk(OFS_CTRL, 32'h38);
    rdChk(OFS_PRE, 32'h1002);
    rdChk(OFS_SYNC, 32'h2dd4_2dd4);
    // An eight-deep FIFO keeps only the four low bits of the threshold.
    rdChk(OFS_AFULL, 32'(AFULL_RST[3:0]));
    // An unmapped place answers with an error both ways.
    axr(8'h24, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(8'h24, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  // Steady ones never form a preamble, so each revision's timer runs out on its own count.
  task automatic testTimeouts();
    logic [1:0] r;
    int lim[3] = '{16, 52, 8};
    for (int v = 0; v < 3; v++)
    begin
      axw(OFS_CTRL, 32'h0, r);
      axw(OFS_MASK, 32'h4, r);
      axw(OFS_CTRL, 32'(v * 4 + 1), r);
      src.sendConst(1'b1, lim[v] - 1);
      rdChk(OFS_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      src.sendConst(1'b1, 1);
      chk({31'h0, irq}, 32'h1);
      rdChk(OFS_STAT, 32'h4);
      repeat (2) @(posedge sysClk);
      chk({31'h0, irq}, 32'h0);
    end
  endtask

  // Two-byte sync, middle revision: 56 bits pass its 52-bit limit after the preamble.
  task automatic testSyncPayload();
    logic [1:0] r;
    logic [7:0] bytes[7] = '{8'h00, 8'haa, 8'h2d, 8'hd4, 8'ha5, 8'h3c, 8'h00};
    axw(OFS_CTRL, 32'h0, r);
    axw(OFS_AFULL, 32'h2, r);
    axw(OFS_MASK, 32'h2, r);
    axw(OFS_CTRL, 32'h15, r);
    foreach (bytes[i])
    begin
      src.sendByte(bytes[i]);
    end
    chk({31'h0, irq}, 32'h1);
    rdChk(OFS_STAT, 32'h030b);
    rdChk(OFS_FIFO, 32'ha5);
    rdChk(OFS_FIFO, 32'h3c);
    rdChk(OFS_FIFO, 32'h00);
    rdChk(OFS_FIFO, 32'h00);
    rdChk(OFS_STAT, 32'h0);
  endtask

  // Tracking doubles the settle time, so a sync byte and an alternating byte inside it must not count.
  // The late timer fires at 8 bits, masked, and the ninth payload byte overflows the FIFO.
  task automatic testSettleOverflow();
    logic [1:0] r;
    axw(OFS_CTRL, 32'h0, r);
    axw(OFS_MASK, 32'h10, r);
    axw(OFS_CTRL, 32'h0b, r);
    src.sendByte(8'h2d);
    src.sendByte(8'haa);
    chk({31'h0, irq}, 32'h0);
    rdChk(OFS_STAT, 32'h4);
    src.sendByte(8'haa);
    src.sendByte(8'h2d);
    for (int i = 1; i < 10; i++)
    begin
      src.sendByte(8'(i));
    end
    chk({31'h0, irq}, 32'h1);
    rdChk(OFS_STAT, 32'h081b);
    rdChk(OFS_FIFO, 32'h01);
    rdChk(OFS_STAT, 32'h0700);
  endtask

  task automatic testTracking();
    logic [1:0] r;
    axw(OFS_CTRL, 32'h2, r);
    src.offset(16'h1234);
    rdChk(OFS_FOFS1, 32'h12);
    rdChk(OFS_FOFS2, 32'h34);
    axw(OFS_CTRL, 32'h0, r);
    src.offset(16'h9999);
    rdChk(OFS_FOFS1, 32'h12);
    axw(OFS_FOFS2, 32'h77, r);
    rdChk(OFS_FOFS2, 32'h77);
  endtask

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    testResetValues();
    testTimeouts();
    testSyncPayload();
    testSettleOverflow();
    testTracking();
    results();
  end
endmodule
